/* verilog/ubrg_pkg.sv */
// Purpose: Constants and types for the baud-rate generator.
// Assumes: APB slave, 32-bit data, one clock pclk at 100 MHz.
// Notes:   Register offsets are byte addresses.
package ubrg_pkg;

  localparam logic [7:0] UBRG_MODE_OFS = 8'h04;
  localparam logic [7:0] UBRG_BAUD_OFS = 8'h20;
  localparam logic [7:0] UBRG_STAT_OFS = 8'h24;
  localparam logic [7:0] UBRG_CLKEN_OFS = 8'h28;

  // Mode register fields
  localparam int UBRG_MODE_LSB  = 0;   // 4-bit operating mode
  localparam int UBRG_SRC_LSB   = 4;   // 2-bit clock_source_select
  localparam int UBRG_SYNC_BIT  = 8;
  localparam int UBRG_OVER_BIT  = 19;
  localparam int UBRG_MODEM_BIT = 20;  // modem control request
  // Baud register fields
  localparam int UBRG_DIV_LSB   = 0;
  localparam int UBRG_FRAC_LSB  = 16;

  localparam logic [3:0] UBRG_MODE_NORMAL = 4'h0;
  localparam logic [4:0] UBRG_OVS16 = 5'h0F;
  localparam logic [4:0] UBRG_OVS8  = 5'h07;
  localparam logic [3:0] UBRG_MCK_DIV = 4'h8;
  localparam logic [3:0] UBRG_FRAC_STEPS = 4'h8;

  typedef enum logic [1:0] {
    UBRG_SRC_MCK  = 2'h0,
    UBRG_SRC_DIV  = 2'h1,
    UBRG_SRC_RSV  = 2'h2,
    UBRG_SRC_EXT  = 2'h3
  } ubrg_src_t;

  typedef struct packed {
    logic       modem_req;
    logic       over;
    logic       sync;
    ubrg_src_t  clock_source_select;
    logic [3:0] op_mode;
  } ubrg_mode_t;

  typedef struct packed {
    logic [2:0]  fraction_part;
    logic [15:0] baud_divisor;
  } ubrg_baud_t;

  typedef struct packed {
    logic sample_tick;
    logic bit_tick;
  } ubrg_tick_t;

endpackage

/* verilog/ubrg_edge.sv */
// Purpose: Synchronise the external serial clock and flag rising edges.
// Assumes: Pin levels last longer than one pclk period.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/10ps
module ubrg_edge (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin and edge
  input  wire logic sck_in,
  output logic      sck_rise,
  output logic      sck_level
);
  logic meta;
  logic sync;
  logic prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= sck_in;
      sync <= meta;
      prev <= sync;
    end
  end

  assign sck_rise  = sync & ~prev;
  assign sck_level = sync;
endmodule // ubrg_edge

/* verilog/ubrg_top.sv */
// Purpose: Baud-rate generator with APB register access.
// Assumes: pclk 100 MHz; serial clock pin obeys level and rate limits.
// Notes:   Ticks are one-cycle pulses on pclk.
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module ubrg_top
  import ubrg_pkg::*;
#(
  parameter bit HAS_MODEM = 1'b1
) (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial clock pin
  input  wire logic        sck_in,
  // Ticks and modem control
  output logic             sample_tick,
  output logic             bit_tick,
  output logic             modem_out
);

  ubrg_mode_t mode_config_reg;
  ubrg_baud_t baud_generator_reg;
  logic       clk_run;
  logic [15:0] div_cnt;
  logic [2:0]  frac_acc;
  logic        frac_extra;
  logic [4:0]  ovs_cnt;
  logic [2:0]  pre_cnt;
  ubrg_tick_t  tick;
  logic [31:0] rd_mux;

  // The prescaler counter is three bits wide
  if (UBRG_MCK_DIV < 4'h2 || UBRG_MCK_DIV > 4'h8) begin : g_bad_div
    $error("prescale factor out of range");
  end

  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & ~pwrite;
  wire hit_mode  = (paddr == UBRG_MODE_OFS);
  wire hit_baud  = (paddr == UBRG_BAUD_OFS);
  wire hit_stat  = (paddr == UBRG_STAT_OFS);
  wire hit_clken = (paddr == UBRG_CLKEN_OFS);
  wire hit_any   = hit_mode | hit_baud | hit_stat | hit_clken;

  // Field positions follow the package, not the struct layout
  ubrg_mode_t  wr_mode;
  logic [31:0] mode_rd;
  assign wr_mode.op_mode   = pwdata[UBRG_MODE_LSB +: 4];
  assign wr_mode.clock_source_select =
           ubrg_src_t'(pwdata[UBRG_SRC_LSB +: 2]);
  assign wr_mode.sync      = pwdata[UBRG_SYNC_BIT];
  assign wr_mode.over      = pwdata[UBRG_OVER_BIT];
  assign wr_mode.modem_req = pwdata[UBRG_MODEM_BIT];
  assign mode_rd = (32'(mode_config_reg.op_mode) << UBRG_MODE_LSB)
                 | (32'(mode_config_reg.clock_source_select) << UBRG_SRC_LSB)
                 | (32'(mode_config_reg.sync) << UBRG_SYNC_BIT)
                 | (32'(mode_config_reg.over) << UBRG_OVER_BIT)
                 | (32'(mode_config_reg.modem_req) << UBRG_MODEM_BIT);

  // Writes are taken regardless of clk_run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_config_reg    <= '0;
      baud_generator_reg <= '0;
      clk_run            <= 1'b0;
    end else if (wr_en) begin
      if (hit_mode) mode_config_reg <= wr_mode;
      if (hit_baud) baud_generator_reg <= ubrg_baud_t'(pwdata[18:0]);
      if (hit_clken) clk_run <= pwdata[0];
    end
  end

  assign rd_mux = hit_mode  ? mode_rd :
                  hit_baud  ? {13'h0000, baud_generator_reg} :
                  hit_stat  ? {16'h0000, div_cnt} :
                  hit_clken ? {31'h00000000, clk_run} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h00000000;
    else if (rd_en && !penable) prdata <= rd_mux;
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // Modem output is held low on instances without the pins; the register bit still reads back
  assign modem_out = HAS_MODEM ? mode_config_reg.modem_req : 1'b0;

  // Source selection
  logic sck_rise;
  ubrg_edge u_edge (
    .pclk      (pclk),
    .presetn   (presetn),
    .sck_in    (sck_in),
    .sck_rise  (sck_rise),
    .sck_level ()
  );

  wire pre_tick = (pre_cnt == 3'(UBRG_MCK_DIV - 4'h1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pre_cnt <= 3'h0;
    else if (clk_run) pre_cnt <= pre_tick ? 3'h0 : pre_cnt + 3'h1;
  end

  logic src_en;
  always_comb begin
    case (mode_config_reg.clock_source_select)
      UBRG_SRC_MCK: src_en = 1'b1;
      UBRG_SRC_DIV: src_en = pre_tick;
      UBRG_SRC_EXT: src_en = sck_rise;
      default:      src_en = 1'b0;
    endcase
  end
  wire step = src_en & clk_run;
  wire ext_sync = mode_config_reg.sync &&
                  mode_config_reg.clock_source_select == UBRG_SRC_EXT;

  // Divider
  wire [15:0] divisor = baud_generator_reg.baud_divisor;
  wire frac_on = (baud_generator_reg.fraction_part != 3'h0) &&
                 (mode_config_reg.op_mode == UBRG_MODE_NORMAL) &&
                 !mode_config_reg.sync;
  wire [3:0] frac_sum = {1'b0, frac_acc} +
                        {1'b0, baud_generator_reg.fraction_part};
  wire [15:0] limit = frac_extra ? divisor : divisor - 16'h0001;
  wire div_done = (divisor == 16'h0001) ? step :
                  (divisor != 16'h0000) && step && (div_cnt >= limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt    <= 16'h0000;
      frac_acc   <= 3'h0;
      frac_extra <= 1'b0;
    end else if (divisor == 16'h0000) begin
      div_cnt    <= 16'h0000;
    end else if (div_done) begin
      div_cnt    <= 16'h0000;
      frac_acc   <= frac_on ? frac_sum[2:0] : 3'h0;
      frac_extra <= frac_on & frac_sum[3];
    end else if (step) begin
      div_cnt    <= div_cnt + 16'h0001;
    end
  end

  // Oversampling
  wire [4:0] ovs_max = mode_config_reg.over ? UBRG_OVS8 : UBRG_OVS16;
  wire ovs_done = div_done && ovs_cnt >= ovs_max;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ovs_cnt <= 5'h00;
    else if (mode_config_reg.sync) ovs_cnt <= 5'h00;
    // A switch to 8x can strand the count above its new top
    else if (ovs_cnt > ovs_max) ovs_cnt <= 5'h00;
    else if (div_done) ovs_cnt <= ovs_done ? 5'h00 : ovs_cnt + 5'h01;
  end

  always_comb begin
    tick.sample_tick = div_done & ~mode_config_reg.sync;
    if (ext_sync) tick.bit_tick = sck_rise & clk_run;
    else if (mode_config_reg.sync) tick.bit_tick = div_done;
    else tick.bit_tick = ovs_done;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_tick <= 1'b0;
      bit_tick    <= 1'b0;
    end else begin
      sample_tick <= tick.sample_tick;
      bit_tick    <= tick.bit_tick;
    end
  end

  // Assertions
  zero_div_a: assert property (@(posedge pclk) disable iff (!presetn)
    (divisor == 16'h0000 && !ext_sync) |=> !bit_tick && !sample_tick)
    else $error("tick with zero divisor");
  bypass_a: assert property (@(posedge pclk) disable iff (!presetn)
    (divisor == 16'h0001 && step && !mode_config_reg.sync) |=> sample_tick)
    else $error("bypass missed a source tick");
  halt_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!clk_run && !(wr_en && hit_baud)) |=> $stable(div_cnt))
    else $error("divider moved while halted");
  cfg_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_baud) |=> baud_generator_reg == $past(pwdata[18:0]))
    else $error("baud write lost");
  over_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    ovs_cnt <= (mode_config_reg.over ? UBRG_OVS8 : UBRG_OVS16) ||
    $changed(mode_config_reg.over))
    else $error("oversample count out of range");
  sync_nosample_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode_config_reg.sync |=> !sample_tick || $changed(mode_config_reg.sync))
    else $error("sample tick in sync mode");
  ext_clk_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ext_sync && sck_rise && clk_run) |=> bit_tick)
    else $error("external clock edge not passed");
  modem_a: assert property (@(posedge pclk) disable iff (!presetn)
    !HAS_MODEM |-> !modem_out)
    else $error("modem output without pins");
  frac_a: assert property (@(posedge pclk) disable iff (!presetn)
    !frac_on && div_done |=> !frac_extra)
    else $error("fraction used while disabled");

  // Register side
  mode_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && hit_mode) |=> mode_config_reg == $past(wr_mode))
    else $error("mode write lost");
  clken_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && hit_clken) |=> clk_run == $past(pwdata[0]))
    else $error("clock enable write lost");
  rd_baud_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !pwrite && !penable && hit_baud) |=>
      prdata == {13'h0000, $past(baud_generator_reg)})
    else $error("baud read wrong");
  unmapped_rd_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !pwrite && !penable && !hit_any) |=> prdata == 32'h00000000)
    else $error("unmapped read not zero");
  unmapped_wr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && !hit_any) |=> $stable(baud_generator_reg) &&
      $stable(mode_config_reg) && $stable(clk_run))
    else $error("unmapped write landed");

  // Source side
  pre_range_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    {1'b0, pre_cnt} < UBRG_MCK_DIV)
    else $error("prescaler out of range");
  pre_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !clk_run |=> $stable(pre_cnt))
    else $error("prescaler moved while halted");
  rsv_src_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode_config_reg.clock_source_select == UBRG_SRC_RSV) |-> !step)
    else $error("reserved source stepped");
  rise_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    sck_rise |=> !sck_rise)
    else $error("edge flag longer than a cycle");
  rise_delay_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    sck_rise |-> $past(sck_in, 2) && !$past(sck_in, 3))
    else $error("edge flag not from a synced rise");

  // Divider and oversampler steps
  sequence div_end_s;
    div_done && divisor > 16'h0001;
  endsequence
  sequence ovs_wrap_s;
    !mode_config_reg.sync && div_done && ovs_cnt == ovs_max;
  endsequence
  sequence bit_out_s;
    bit_tick && ovs_cnt == 5'h00;
  endsequence

  div_restart_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    div_end_s |=> div_cnt == 16'h0000)
    else $error("divider did not restart");
  zero_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (divisor == 16'h0000) |=> div_cnt == 16'h0000)
    else $error("divider ran with zero divisor");
  spacing_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (sample_tick && divisor > 16'h0001) |=> !sample_tick)
    else $error("sample ticks too close");
  ovs_wrap_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ovs_wrap_s |=> bit_out_s)
    else $error("oversampler wrap missed bit tick");
  sample_bit_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (bit_tick && !$past(mode_config_reg.sync)) |-> sample_tick)
    else $error("bit tick without sample tick");
  sync_bit_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode_config_reg.sync && !ext_sync && div_done) |=> bit_tick)
    else $error("sync divider output lost");
  frac_acc_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!frac_on && div_done) |=> frac_acc == 3'h0)
    else $error("fraction accumulated while disabled");
endmodule // ubrg_top

/* verif/ubrg_sck_src.sv */
// Purpose: Remote party driving the serial clock pin.
// Assumes: Driven from pclk; HALF of 3 or more keeps the rate legal.
// Notes:   Pin rests low between bursts, as a gated clock would.
`timescale 1ns/10ps
module ubrg_sck_src #(
  parameter int HALF = 5
) (
  // Clock
  input  wire logic pclk,
  // Control
  input  wire logic run,
  // Pin
  output logic      sck
);
  int cnt;

  // Each level lasts HALF pclk periods, so the rate is 1/(2*HALF)
  always @(posedge pclk) begin
    if (!run) begin
      sck <= 1'b0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      sck <= ~sck;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // ubrg_sck_src

/* verif/usart_baud_rate_generator_tb_top.sv */
// Purpose: Self-checking bench for the baud-rate generator.
// Assumes: Zero-wait APB slave; sck source with 10-cycle period.
// Notes:   Tick periods are measured on the falling edge of pclk.
`timescale 1ns/10ps
module usart_baud_rate_generator_tb_top;
  import ubrg_pkg::*;
  typedef struct {ubrg_src_t s; bit sy; bit ov; int d; int es; int eb;} row_t;
  logic        pclk, presetn, psel, penable, pwrite, sck_in, sck_run, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, a;
  logic        pready, pslverr, sample_tick, bit_tick, modem_out;
  int          n_errors, checks_done, n, i, r, t;
  // Small exact divisors keep the bit-rate error at zero
  // No interrupt line leaves this block; detection is the router's
  row_t rows[6] = '{'{UBRG_SRC_MCK, 0, 0, 3, 3, 48},
                    '{UBRG_SRC_MCK, 0, 1, 5, 5, 40},
                    '{UBRG_SRC_DIV, 0, 1, 2, 16, 128},
                    '{UBRG_SRC_EXT, 0, 1, 2, 20, 160},
                    '{UBRG_SRC_MCK, 1, 0, 4, 0, 4},
                    '{UBRG_SRC_MCK, 0, 1, 1, 1, 8}};

  ubrg_top #(.HAS_MODEM(1'b1)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sck_in(sck_in), .sample_tick(sample_tick), .bit_tick(bit_tick),
    .modem_out(modem_out));
  ubrg_sck_src #(.HALF(5)) src (.pclk(pclk), .run(sck_run), .sck(sck_in));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    if (k >= 50) begin
      n_errors++;
      stop_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Aligns on one tick, then counts cycles over k further ticks
  task automatic span(input bit bt, input int k, output int c);
    int j;
    for (j = 0; j <= k; j++) begin
      if (j == 1) c = 0;
      do begin
        @(negedge pclk);
        c++;
      end while ((bt ? bit_tick : sample_tick) !== 1'b1 && c < 3000);
      if (c >= 3000) begin
        n_errors++;
        stop_test();
      end
    end
  endtask

  // Counts ticks and pin rises over a fixed window
  task automatic tally(input int w, output int ts, output int tb, output int sr);
    logic p;
    ts = 0;
    tb = 0;
    sr = 0;
    p = sck_in;
    repeat (w) begin
      @(negedge pclk);
      ts += (sample_tick === 1'b1);
      tb += (bit_tick === 1'b1);
      sr += (sck_in === 1'b1 && p === 1'b0);
      p = sck_in;
    end
  endtask

  function automatic logic [31:0] mode(ubrg_src_t s, bit sy, bit ov);
    return (32'(s) << UBRG_SRC_LSB) | (32'(sy) << UBRG_SYNC_BIT)
         | (32'(ov) << UBRG_OVER_BIT);
  endfunction

  initial begin
    {psel, penable, pwrite, sck_run, paddr, pwdata} = '0;
    n_errors = 0;
    checks_done = 0;
    n = 0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    check("tick in reset", {sample_tick, bit_tick}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h3C, 32'h0);
    check("unmapped err", err, 32'h1);
    check("unmapped data", rd, 32'h0);
    // Configuration lands while the clock is stopped, ticks stay off
    apb(1'b1, UBRG_BAUD_OFS, 32'h2);
    apb(1'b1, UBRG_MODE_OFS, mode(UBRG_SRC_MCK, 0, 1));
    tally(100, t, r, n);
    check("ticks clock off", t + r, 32'h0);
    apb(1'b1, UBRG_CLKEN_OFS, 32'h1);
    span(1'b0, 1, n);
    check("sample after on", n, 32'h2);
    for (i = 0; i < 6; i++) begin
      sck_run <= (rows[i].s == UBRG_SRC_EXT);
      apb(1'b1, UBRG_MODE_OFS, mode(rows[i].s, rows[i].sy, rows[i].ov));
      apb(1'b1, UBRG_BAUD_OFS, 32'(rows[i].d));
      if (rows[i].es != 0) span(1'b0, 1, n);
      if (rows[i].es != 0) check("sample period", n, rows[i].es);
      span(1'b1, 1, n);
      check("bit period", n, rows[i].eb);
    end
    // Three extra cycles per eight sample periods
    apb(1'b1, UBRG_MODE_OFS, mode(UBRG_SRC_MCK, 0, 1));
    apb(1'b1, UBRG_BAUD_OFS, (32'h3 << UBRG_FRAC_LSB) | 32'h2);
    span(1'b0, 8, n);
    check("frac 8 samples", n, 32'd19);
    span(1'b1, 1, n);
    check("frac bit", n, 32'd19);
    apb(1'b1, UBRG_MODE_OFS, mode(UBRG_SRC_MCK, 0, 1) | 32'h1);
    span(1'b0, 8, n);
    check("frac special", n, 32'd16);
    apb(1'b1, UBRG_BAUD_OFS, 32'h0);
    tally(200, t, r, n);
    check("div zero", t + r, 32'h0);
    // Stopped clock freezes the divider count
    apb(1'b1, UBRG_BAUD_OFS, 32'h0FFF);
    repeat (7) @(posedge pclk);
    apb(1'b1, UBRG_CLKEN_OFS, 32'h0);
    apb(1'b0, UBRG_STAT_OFS, 32'h0);
    a = rd;
    repeat (30) @(posedge pclk);
    apb(1'b0, UBRG_STAT_OFS, 32'h0);
    check("count held", rd, a);
    apb(1'b1, UBRG_CLKEN_OFS, 32'h1);
    apb(1'b1, UBRG_MODE_OFS, mode(UBRG_SRC_EXT, 1, 0) | (32'h1 << 20));
    check("modem out", modem_out, 32'h1);
    sck_run <= 1'b1;
    tally(400, t, r, n);
    sck_run <= 1'b0;
    tally(3, t, i, a);
    check("sync ext bits", r + i, n);
    stop_test();
  end
endmodule // usart_baud_rate_generator_tb_top
